/* hdl/ext_irq_cfg.svh */
// Offsets, field positions, reset values and timing of the external interrupt unit
`ifndef EXT_IRQ_CFG_SVH
`define EXT_IRQ_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_SENSE 6'h00
`define OFS_STATUS 6'h04
`define OFS_MASK 6'h08
`define OFS_PC_MASK 6'h0C
`define OFS_CPU_STATUS 6'h10
`define OFS_STACK_PTR 6'h14
`define OFS_VECTOR 6'h18
`define OFS_PIN_LEVEL 6'h1C

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define GIE_BIT 7
`define RST_SENSE 16'h0000
`define RST_STACK_PTR 16'hFFFF

// ----------------------------------------
// Vector addresses
// ----------------------------------------
`define VEC_RESET 16'h0000
`define VEC_LINE0 16'h0002
`define VEC_LINE7 16'h0010
`define VEC_GRP0 16'h0012
`define VEC_GRP1 16'h0014
`define VEC_GRP2 16'h0016
`define VEC_STEP 16'h0002
`define PC_BYTES 16'h0002

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ 200
`define MIN_PULSE_NS 50
`define MIN_PULSE_CYC ((`MIN_PULSE_NS * `CLK_MHZ + 999) / 1000)

`endif

/* hdl/ext_irq_pkg.sv */
// Types shared by the external interrupt unit
package ext_irq_pkg;
   typedef enum logic [1:0] {
      SENSE_LOW = 2'h0,
      SENSE_ANY = 2'h1,
      SENSE_FALL = 2'h2,
      SENSE_RISE = 2'h3
   } sense_mode_t;
endpackage

/* hdl/ext_irq_sense.sv */
// Sense logic of one dedicated interrupt line
`timescale 1ns/1ps

module ext_irq_sense
   import ext_irq_pkg::*;
#(
   parameter bit SYNC = 1'b0
) (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_sample_en,
   input wire logic i_pin,
   input wire sense_mode_t i_sense,
   output logic o_hit
);
   logic stage;
   logic prev;
   logic fresh;
   logic armed;

   // Unclocked lines compare the live pin with its last value; sampled lines
   // compare two samples and only right after a sample was taken.
   wire logic take = !SYNC || i_sample_en;
   wire logic lvl = SYNC ? stage : i_pin;
   wire logic last = SYNC ? prev : stage;
   wire logic ok = SYNC ? fresh : armed;
   wire logic rise = ok && lvl && !last;
   wire logic fall = ok && !lvl && last;
   wire logic low = armed && !lvl;

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         stage <= 1'b0;
         prev <= 1'b0;
         fresh <= 1'b0;
         armed <= 1'b0;
      end else if (take) begin
         stage <= i_pin;
         prev <= stage;
         fresh <= armed;
         armed <= 1'b1;
      end else begin
         fresh <= 1'b0;
      end
   end

   assign o_hit = (i_sense == SENSE_LOW) ? low : // RULE_09
                  (i_sense == SENSE_ANY) ? (rise || fall) :
                  (i_sense == SENSE_FALL) ? fall : rise;

endmodule // ext_irq_sense

/* hdl/ext_irq_unit.sv */
// External interrupt sensing unit with Avalon-MM register slave
//
// Chosen here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`include "ext_irq_cfg.svh"

// Behaviour
// RULE_01 - Lines 0 to 7 vector to even addresses 0x0002 up to 0x0010; reset is 0x0000.
// RULE_02 - Any enabled pin change in group 0 raises one request vectored to 0x0012.
// RULE_03 - Groups 1 and 2 raise their own requests, vectored to 0x0014 and 0x0016.
// RULE_04 - Group pins are merged by OR with no source indication; software compares.
// RULE_05 - Sampled lines need the I/O clock; only unclocked sources may wake the part.
// RULE_06 - Lines 0 to 3 are sensed unclocked; a pulse over the 50 ns minimum is caught.
// RULE_07 - Lines 4 to 7 are sampled first; an edge held over one clock period is caught.
// RULE_08 - Pin-change sources have no sense select and request on any level change.
// RULE_09 - Sense select 00 low level, 01 any edge, 10 falling edge, 11 rising edge.
// RULE_10 - A low-level source must be held low by its driver long enough to be seen.
// RULE_11 - Acceptance pushes only the return address and moves the stack pointer.
// RULE_12 - Among pending requests the lowest vector address is served first.
// RULE_13 - An enabled low-level source requests for as long as the pin stays low.
// RULE_14 - Pins are sensed whatever their direction, so software can trigger requests.
// RULE_15 - Acceptance clears the global enable until software sets it again.
// RULE_16 - Flags latch on detection; a request needs its own and the global enable.

module ext_irq_unit
   import ext_irq_pkg::*;
#(
   parameter int N_LINES = 8,
   parameter int N_ASYNC = 4,
   parameter int N_GROUPS = 3,
   parameter int GROUP_W = 8
) (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic [5:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   input wire logic [3:0] i_byteenable,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   input wire logic [N_LINES-1:0] i_dedicated_irq_line,
   input wire logic [N_GROUPS*GROUP_W-1:0] i_pin_change_line,
   input wire logic i_io_clock_run,
   input wire logic i_irq_ack,
   input wire logic [15:0] i_return_pc,
   output logic o_irq,
   output logic [15:0] o_vector,
   output logic o_push_valid,
   output logic [15:0] o_push_addr,
   output logic [15:0] o_push_data,
   output logic o_wake
);
   localparam int N_SRC = N_LINES + N_GROUPS;
   localparam int N_PIN = N_GROUPS * GROUP_W;
   localparam int IW = $clog2(N_SRC);
   localparam int min_pulse_cyc = `MIN_PULSE_CYC;
   localparam logic [N_SRC-1:0] ASYNC_MAP =
      {{N_GROUPS{1'b1}}, {(N_LINES - N_ASYNC){1'b0}}, {N_ASYNC{1'b1}}};

   logic [2*N_LINES-1:0] sense;
   logic [N_SRC-1:0] status;
   logic [N_SRC-1:0] mask;
   logic [N_PIN-1:0] pc_mask;
   logic [N_PIN-1:0] pc_prev;
   logic pc_armed;
   logic gie;
   logic [15:0] stack_ptr;
   logic [N_LINES-1:0] line_hit;
   logic [N_GROUPS-1:0] grp_set;

   function automatic logic [IW-1:0] first_idx(input logic [N_SRC-1:0] v);
      logic [IW-1:0] r;
      r = '0;
      for (int k = N_SRC - 1; k >= 0; k--) begin
         if (v[k]) begin
            r = IW'(k);
         end
      end
      return r;
   endfunction

   function automatic logic [15:0] vec_of(input logic [IW-1:0] idx);
      logic [15:0] r;
      if (idx < IW'(N_LINES)) begin
         r = `VEC_LINE0 + `VEC_STEP * 16'(idx);
      end else begin
         r = `VEC_GRP0 + `VEC_STEP * 16'(idx - IW'(N_LINES));
      end
      return r;
   endfunction

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   wire logic req = i_read || i_write;
   wire logic take = req && !o_waitrequest;
   wire logic wr = i_write && take;
   wire logic [31:0] be_mask = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}},
                                {8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
   wire logic [31:0] wd_m = i_writedata & be_mask;
   wire logic hit_sense = i_address == `OFS_SENSE;
   wire logic hit_status = i_address == `OFS_STATUS;
   wire logic hit_mask = i_address == `OFS_MASK;
   wire logic hit_pcm = i_address == `OFS_PC_MASK;
   wire logic hit_cpu = i_address == `OFS_CPU_STATUS;
   wire logic hit_sp = i_address == `OFS_STACK_PTR;
   wire logic hit_vec = i_address == `OFS_VECTOR;
   wire logic hit_pin = i_address == `OFS_PIN_LEVEL;
   wire logic [31:0] sense_w = (32'(sense) & ~be_mask) | wd_m;
   wire logic [31:0] mask_w = (32'(mask) & ~be_mask) | wd_m;
   wire logic [31:0] pcm_w = (32'(pc_mask) & ~be_mask) | wd_m;
   wire logic [31:0] sp_w = (32'(stack_ptr) & ~be_mask) | wd_m;
   wire logic [31:0] rd_mux =
      hit_sense ? 32'(sense) :
      hit_status ? 32'(status) :
      hit_mask ? 32'(mask) :
      hit_pcm ? 32'(pc_mask) :
      hit_cpu ? (32'(gie) << `GIE_BIT) :
      hit_sp ? 32'(stack_ptr) :
      hit_vec ? 32'(o_vector) :
      hit_pin ? 32'(i_pin_change_line) : 32'h0000_0000;

   // ----------------------------------------
   // Source detection
   // ----------------------------------------
   // Pins are taken as levels only, with no direction gating at all.
   for (genvar i = 0; i < N_LINES; i++) begin : g_line
      ext_irq_sense #(
         .SYNC(i >= N_ASYNC)
      ) u_sense (
         .i_clock(i_clock),
         .i_rst_n(i_rst_n),
         .i_sample_en(i_io_clock_run), // RULE_05
         .i_pin(i_dedicated_irq_line[i]), // RULE_14
         .i_sense(sense_mode_t'(sense[2*i +: 2])), // RULE_06 RULE_07
         .o_hit(line_hit[i])
      );
   end

   // Any enabled pin toggling is one event; the source pin is not kept.
   wire logic [N_PIN-1:0] pc_change =
      (i_pin_change_line ^ pc_prev) & pc_mask & {N_PIN{pc_armed}}; // RULE_08
   for (genvar g = 0; g < N_GROUPS; g++) begin : g_grp
      assign grp_set[g] = |pc_change[g*GROUP_W +: GROUP_W]; // RULE_04
   end

   // A low level re-sets its flag every cycle, so the request stays while low.
   wire logic [N_SRC-1:0] set_vec = {grp_set, line_hit}; // RULE_10 RULE_13

   // ----------------------------------------
   // Acceptance and next state
   // ----------------------------------------
   wire logic [N_SRC-1:0] pend_en = status & mask & {N_SRC{gie}}; // RULE_16
   wire logic ack_fire = i_irq_ack && o_irq && (|pend_en);
   wire logic [IW-1:0] sel_idx = first_idx(pend_en); // RULE_12
   wire logic [N_SRC-1:0] ack_clr =
      ack_fire ? ({{(N_SRC-1){1'b0}}, 1'b1} << sel_idx) : '0;
   wire logic [N_SRC-1:0] bus_clr = (wr && hit_status) ? wd_m[N_SRC-1:0] : '0;
   // Set wins over either clear so an event in the clearing cycle survives.
   wire logic [N_SRC-1:0] next_status = (status & ~bus_clr & ~ack_clr) | set_vec;
   wire logic [N_SRC-1:0] next_mask = (wr && hit_mask) ? mask_w[N_SRC-1:0] : mask;
   wire logic next_gie = ack_fire ? 1'b0 : // RULE_15
      (wr && hit_cpu && i_byteenable[0]) ? i_writedata[`GIE_BIT] : gie;
   wire logic [15:0] next_sp = ack_fire ? stack_ptr - `PC_BYTES : // RULE_11
      (wr && hit_sp) ? sp_w[15:0] : stack_ptr;
   wire logic next_irq = |(next_status & next_mask & {N_SRC{next_gie}}); // RULE_16
   // Wake ignores the sampled lines: their clock is stopped in deep sleep.
   wire logic next_wake = |(next_status & next_mask & ASYNC_MAP); // RULE_05

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_waitrequest <= 1'b1;
         o_readdata <= 32'h0000_0000;
      end else begin
         o_waitrequest <= !(req && o_waitrequest);
         if (i_read && o_waitrequest) begin
            o_readdata <= rd_mux;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         sense <= `RST_SENSE;
         mask <= '0;
         pc_mask <= '0;
         gie <= 1'b0;
         stack_ptr <= `RST_STACK_PTR;
      end else begin
         sense <= (wr && hit_sense) ? sense_w[2*N_LINES-1:0] : sense;
         mask <= next_mask;
         pc_mask <= (wr && hit_pcm) ? pcm_w[N_PIN-1:0] : pc_mask;
         gie <= next_gie;
         stack_ptr <= next_sp;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         status <= '0;
         pc_prev <= '0;
         pc_armed <= 1'b0;
      end else begin
         status <= next_status;
         pc_prev <= i_pin_change_line;
         pc_armed <= 1'b1;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_irq <= 1'b0;
         o_wake <= 1'b0;
         o_vector <= `VEC_RESET;
         o_push_valid <= 1'b0;
         o_push_addr <= 16'h0000;
         o_push_data <= 16'h0000;
      end else begin
         o_irq <= next_irq;
         o_wake <= next_wake;
         o_push_valid <= ack_fire;
         if (ack_fire) begin
            o_vector <= vec_of(sel_idx); // RULE_01 RULE_02 RULE_03
            o_push_addr <= stack_ptr; // RULE_11
            o_push_data <= i_return_pc;
         end
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_vec_line;
      @(posedge i_clock) disable iff (!i_rst_n)
      (ack_fire && sel_idx == '0) |=> o_vector == `VEC_LINE0 && o_push_valid;
   endproperty
   a_vec_line: assert property (p_vec_line) else $error("line 0 vector wrong"); // RULE_01

   property p_vec_line7;
      @(posedge i_clock) disable iff (!i_rst_n)
      (ack_fire && sel_idx == IW'(N_LINES - 1)) |=> o_vector == `VEC_LINE7;
   endproperty
   a_vec_line7: assert property (p_vec_line7) else $error("line 7 vector wrong"); // RULE_01

   property p_vec_grp0;
      @(posedge i_clock) disable iff (!i_rst_n)
      (ack_fire && sel_idx == IW'(N_LINES)) |=> o_vector == `VEC_GRP0 && o_push_valid;
   endproperty
   a_vec_grp0: assert property (p_vec_grp0) else $error("group 0 vector wrong"); // RULE_02

   property p_vec_grp12;
      @(posedge i_clock) disable iff (!i_rst_n)
      ack_fire && sel_idx > IW'(N_LINES) |=>
      o_vector == ($past(sel_idx) == IW'(N_LINES + 1) ? `VEC_GRP1 : `VEC_GRP2);
   endproperty
   a_vec_grp12: assert property (p_vec_grp12) else $error("group vector wrong"); // RULE_03

   property p_sampled_halt;
      @(posedge i_clock) disable iff (!i_rst_n)
      (!i_io_clock_run && !$past(i_io_clock_run) &&
       sense[2*N_ASYNC +: 2] != 2'h0) |-> !line_hit[N_ASYNC];
   endproperty
   a_sampled_halt: assert property (p_sampled_halt) else $error("sampled line moved"); // RULE_05

   property p_async_pulse;
      @(posedge i_clock) disable iff (!i_rst_n)
      (pc_armed && sense[1:0] == 2'h1 && $changed(i_dedicated_irq_line[0]))
      |-> ##[1:min_pulse_cyc] status[0];
   endproperty
   a_async_pulse: assert property (p_async_pulse) else $error("line 0 pulse lost"); // RULE_06

   property p_sync_edge;
      @(posedge i_clock) disable iff (!i_rst_n)
      (pc_armed && sense[2*N_ASYNC +: 2] == 2'h3 && i_io_clock_run &&
       !i_dedicated_irq_line[N_ASYNC] ##1 i_io_clock_run &&
       i_dedicated_irq_line[N_ASYNC] && sense[2*N_ASYNC +: 2] == 2'h3)
      |=> line_hit[N_ASYNC] ##1 status[N_ASYNC];
   endproperty
   a_sync_edge: assert property (p_sync_edge) else $error("line 4 edge lost"); // RULE_07

   property p_pc_any;
      @(posedge i_clock) disable iff (!i_rst_n)
      (pc_armed && |((i_pin_change_line[GROUP_W-1:0] ^ $past(i_pin_change_line[GROUP_W-1:0]))
       & pc_mask[GROUP_W-1:0])) |=> status[N_LINES];
   endproperty
   a_pc_any: assert property (p_pc_any) else $error("pin change lost"); // RULE_08

   property p_fall_only;
      @(posedge i_clock) disable iff (!i_rst_n)
      sense[3:2] == 2'h2 && $rose(i_dedicated_irq_line[1]) |-> !line_hit[1];
   endproperty
   a_fall_only: assert property (p_fall_only) else $error("fall mode took rise"); // RULE_09

   property p_push;
      @(posedge i_clock) disable iff (!i_rst_n)
      ack_fire |=> o_push_valid && o_push_data == $past(i_return_pc) &&
      stack_ptr == $past(stack_ptr) - `PC_BYTES;
   endproperty
   a_push: assert property (p_push) else $error("stack push wrong"); // RULE_11

   property p_prio;
      @(posedge i_clock) disable iff (!i_rst_n)
      ack_fire |-> (pend_en & ((N_SRC'(1) << sel_idx) - N_SRC'(1))) == '0 && pend_en[sel_idx];
   endproperty
   a_prio: assert property (p_prio) else $error("priority wrong"); // RULE_12

   property p_level;
      @(posedge i_clock) disable iff (!i_rst_n)
      (pc_armed && sense[1:0] == 2'h0 && !i_dedicated_irq_line[0]) |=> status[0];
   endproperty
   a_level: assert property (p_level) else $error("low level dropped"); // RULE_13

   property p_gie;
      @(posedge i_clock) disable iff (!i_rst_n)
      ack_fire |=> !gie && !o_irq;
   endproperty
   a_gie: assert property (p_gie) else $error("enable not cleared"); // RULE_15

   property p_gate;
      @(posedge i_clock) disable iff (!i_rst_n)
      o_irq |-> gie && |(status & mask);
   endproperty
   a_gate: assert property (p_gate) else $error("ungated request"); // RULE_16

   property p_wake;
      @(posedge i_clock) disable iff (!i_rst_n)
      ((status & mask & ~ASYNC_MAP) != '0 && (status & mask & ASYNC_MAP) == '0) |-> !o_wake;
   endproperty
   a_wake: assert property (p_wake) else $error("sampled line woke"); // RULE_05

   property p_set_wins;
      @(posedge i_clock) disable iff (!i_rst_n)
      (wr && hit_status && wd_m[1] && line_hit[1]) |=> status[1];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("clear beat a low level"); // RULE_13

   property p_push_addr;
      @(posedge i_clock) disable iff (!i_rst_n)
      ack_fire |=> o_push_addr == $past(stack_ptr);
   endproperty
   a_push_addr: assert property (p_push_addr) else $error("push address wrong"); // RULE_11

   property p_ack_clr;
      @(posedge i_clock) disable iff (!i_rst_n)
      (ack_fire && !set_vec[sel_idx]) |=> !status[$past(sel_idx)];
   endproperty
   a_ack_clr: assert property (p_ack_clr) else $error("served flag kept"); // RULE_16

endmodule // ext_irq_unit

/* bench/ext_pin_model.sv */
// Behavioural model of the port pins that feed the external interrupt unit
`timescale 1ns/1ps

module ext_pin_model #(
   parameter int HOLD_LOW = 2
) (
   input wire logic i_clock,
   input wire logic [7:0] i_line_req,
   input wire logic [23:0] i_group_req,
   output logic [7:0] o_dedicated_irq_line,
   output logic [23:0] o_pin_change_line
);
   int low_cnt [8];

   initial begin
      o_dedicated_irq_line = 8'hff;
      o_pin_change_line = 24'h00_0000;
      foreach (low_cnt[n]) low_cnt[n] = 0;
   end

   // A low level is stretched, so a level-sensed line is never left guessing
   always @(posedge i_clock) begin
      for (int n = 0; n < 8; n++) begin
         if (low_cnt[n] > 0) begin
            low_cnt[n] <= low_cnt[n] - 1;
         end else begin
            o_dedicated_irq_line[n] <= i_line_req[n];
            if (!i_line_req[n] && o_dedicated_irq_line[n]) low_cnt[n] <= HOLD_LOW - 1;
         end
      end
      o_pin_change_line <= i_group_req;
   end
endmodule // ext_pin_model

/* bench/tb.sv */
// Self-checking bench of the external interrupt unit
`timescale 1ns/1ps
`include "ext_irq_cfg.svh"
`define CHK(a, b, m) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
   $display("MISMATCH t=%0t %s", $time, m); end end

module tb;
   import ext_irq_pkg::*;
   logic i_clock = 1'b0;
   logic i_rst_n = 1'b0;
   logic [5:0] i_address = 6'h00;
   logic i_read = 1'b0;
   logic i_write = 1'b0;
   logic [31:0] i_writedata = 32'h0000_0000;
   logic [7:0] line_req = 8'hff;
   logic [23:0] group_req = 24'h00_0000;
   logic i_io_clock_run = 1'b1;
   logic i_irq_ack = 1'b0;
   logic [15:0] i_return_pc = 16'h0000;
   logic [31:0] o_readdata;
   logic o_waitrequest;
   logic o_irq;
   logic o_push_valid;
   logic o_wake;
   logic [15:0] o_vector;
   logic [15:0] o_push_addr;
   logic [15:0] o_push_data;
   logic [7:0] pins;
   logic [23:0] pcl;
   logic [31:0] exp_rd [$];
   logic [47:0] exp_push [$];
   logic [31:0] lfsr = 32'hf52d_1cac;
   logic [15:0] sp = `RST_STACK_PTR;
   int bad_count = 0;
   int n_tests = 0;

   always #2.5 i_clock = ~i_clock;

   ext_irq_unit ext_irq_unit_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_address(i_address),
      .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(4'hf),
      .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_dedicated_irq_line(pins),
      .i_pin_change_line(pcl), .i_io_clock_run(i_io_clock_run), .i_irq_ack(i_irq_ack),
      .i_return_pc(i_return_pc), .o_irq(o_irq), .o_vector(o_vector),
      .o_push_valid(o_push_valid), .o_push_addr(o_push_addr), .o_push_data(o_push_data),
      .o_wake(o_wake));

   ext_pin_model ext_pin_model_i (.i_clock(i_clock), .i_line_req(line_req),
      .i_group_req(group_req), .o_dedicated_irq_line(pins), .o_pin_change_line(pcl));

   // ----------------------------------------
   // Result monitor
   // ----------------------------------------
   always @(posedge i_clock) begin
      if (i_read && !o_waitrequest) begin
         `CHK(o_readdata, exp_rd.pop_front(), "register read")
      end
      if (o_push_valid) begin
         `CHK({o_vector, o_push_addr, o_push_data}, exp_push.pop_front(), "push")
      end
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic cyc(input int n);
      repeat (n) @(posedge i_clock);
   endtask

   // One edge passes first, so a strobe is never assigned twice in a time step
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      @(posedge i_clock);
      i_address <= a;
      i_writedata <= d;
      if (w) i_write <= 1'b1;
      else i_read <= 1'b1;
      do @(posedge i_clock); while (o_waitrequest);
      i_write <= 1'b0;
      i_read <= 1'b0;
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rd(input logic [5:0] a, input logic [31:0] e);
      exp_rd.push_back(e);
      bus(1'b0, a, 32'h0000_0000);
   endtask

   task automatic ack(input logic [15:0] vec);
      wr(`OFS_CPU_STATUS, 32'h0000_0080);
      cyc(2);
      #1;
      `CHK(o_irq, 1'b1, "request missing")
      lfsr = lfsr_next(lfsr);
      exp_push.push_back({vec, sp, lfsr[15:0]});
      sp = sp - `PC_BYTES;
      @(posedge i_clock);
      i_irq_ack <= 1'b1;
      i_return_pc <= lfsr[15:0];
      @(posedge i_clock);
      i_irq_ack <= 1'b0;
      rd(`OFS_CPU_STATUS, 32'h0000_0000);
   endtask

   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      #200_000;
      bad_count++;
      test_done();
   end

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      int p;
      int q;
      repeat (3) @(posedge i_clock);
      i_rst_n <= 1'b1;
      // Reset values, with an unmapped word at the end
      for (int a = 0; a < 9; a++) rd(6'(a * 4), (a == 5) ? 32'(`RST_STACK_PTR) : 0);
      // Every sense mode on every line, probed with a fall, then a rise
      for (int n = 0; n < 8; n++) begin
         for (int m = 0; m < 4; m++) begin
            wr(`OFS_SENSE, 32'(m) << (2 * n));
            wr(`OFS_STATUS, 32'h0000_07ff);
            line_req[n] <= 1'b0;
            cyc(4);
            rd(`OFS_STATUS, 32'(m != 3) << n);
            line_req[n] <= 1'b1;
            cyc(4);
         end
         rd(`OFS_STATUS, 32'h1 << n);
      end
      // Sampled line is blind while the I/O clock is stopped
      i_io_clock_run <= 1'b0;
      wr(`OFS_SENSE, 32'h0000_2a20);
      wr(`OFS_STATUS, 32'h0000_07ff);
      line_req[5:4] <= 2'b00;
      cyc(4);
      line_req[5:4] <= 2'b11;
      cyc(4);
      rd(`OFS_STATUS, 32'h0000_0000);
      i_io_clock_run <= 1'b1;
      // Wake comes from unclocked lines only; no request without global enable
      wr(`OFS_MASK, 32'h0000_07ff);
      line_req[6] <= 1'b0;
      cyc(6);
      #1;
      `CHK({o_wake, o_irq}, 2'b00, "sampled line woke")
      line_req[2] <= 1'b0;
      cyc(4);
      #1;
      `CHK({o_wake, o_irq}, 2'b10, "wake or request wrong")
      ack(16'h0006);
      ack(16'h000e);
      line_req <= 8'hff;
      // All lines pending at once are served lowest vector first
      wr(`OFS_SENSE, 32'h0000_5555);
      cyc(6);
      wr(`OFS_STATUS, 32'h0000_07ff);
      line_req <= 8'h00;
      cyc(6);
      for (int n = 0; n < 8; n++) ack(`VEC_LINE0 + 16'(n) * `VEC_STEP);
      wr(`OFS_SENSE, 32'h0000_0000);
      line_req <= 8'hff;
      cyc(6);
      // A held low level keeps its flag up through clears and service
      wr(`OFS_STATUS, 32'h0000_07ff);
      line_req[1] <= 1'b0;
      cyc(4);
      wr(`OFS_STATUS, 32'h0000_0002);
      rd(`OFS_STATUS, 32'h0000_0002);
      wr(`OFS_MASK, 32'h0000_07fd);
      wr(`OFS_CPU_STATUS, 32'h0000_0080);
      cyc(2);
      #1;
      `CHK({o_wake, o_irq}, 2'b00, "masked line requested")
      wr(`OFS_MASK, 32'h0000_07ff);
      ack(16'h0004);
      rd(`OFS_STATUS, 32'h0000_0002);
      line_req[1] <= 1'b1;
      cyc(4);
      wr(`OFS_STATUS, 32'h0000_07ff);
      // Pin-change groups: one random enabled pin, a neighbour left disabled
      for (int g = 0; g < 3; g++) begin
         lfsr = lfsr_next(lfsr);
         p = 8 * g + int'(lfsr[2:0]);
         q = 8 * g + int'(lfsr[2:0] ^ 3'h1);
         wr(`OFS_PC_MASK, 32'h1 << p);
         wr(`OFS_STATUS, 32'h0000_07ff);
         group_req[q] <= ~group_req[q];
         cyc(4);
         rd(`OFS_STATUS, 32'h0000_0000);
         group_req[p] <= ~group_req[p];
         cyc(4);
         rd(`OFS_PIN_LEVEL, {8'h00, group_req});
         rd(`OFS_STATUS, 32'h100 << g);
         #1;
         `CHK(o_wake, 1'b1, "group did not wake")
         ack(`VEC_GRP0 + 16'(g) * `VEC_STEP);
      end
      rd(`OFS_STACK_PTR, {16'h0000, sp});
      cyc(2);
      `CHK(exp_rd.size() + exp_push.size(), 0, "result never seen")
      test_done();
   end
endmodule // tb
